// ### hw/cerc_pkg.sv
// Package with the constants of the cluster error record control block.
package cerc_pkg;
   // ----------------------------------------------------------------
   // Record selection and register layout
   // ----------------------------------------------------------------
   localparam logic [7:0] CERC_RECORD_INDEX = 8'h01;
   localparam int CERC_REG_WIDTH = 64;
   localparam int CERC_ALIAS_WIDTH = 32;
   localparam int CERC_CFI_BIT = 8;
   localparam int CERC_FI_BIT = 3;
   localparam int CERC_UI_BIT = 2;
   localparam int CERC_ED_BIT = 0;
   localparam logic [63:0] CERC_CTRL_RESET = 64'h0000000000000000;
   localparam logic [63:0] CERC_CTRL_MASK = 64'h000000000000010d;
   // ----------------------------------------------------------------
   // Syndrome record overflow bits
   // ----------------------------------------------------------------
   localparam int CERC_OFO_BIT = 47;
   localparam int CERC_OFR_BIT = 39;
   // ----------------------------------------------------------------
   // Alias selectors
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CERC_ALIAS_LOW,
      CERC_ALIAS_HIGH,
      CERC_ALIAS_FULL
   } cerc_alias_t;
   // ----------------------------------------------------------------
   // Redundancy modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CERC_MODE_SPLIT,
      CERC_MODE_LOCK,
      CERC_MODE_HYBRID
   } cerc_mode_t;
endpackage

// ### hw/cerc_top.sv
// Error record control register with its interrupt and reporting gating.
`timescale 1ns/1ns
module cerc_top #(
   parameter bit HAS_CFI = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] record_selector,
   input wire logic alias_wr,
   input wire cerc_pkg::cerc_alias_t alias_sel,
   input wire logic [63:0] alias_wdata,
   output logic [63:0] alias_rdata,
   input wire cerc_pkg::cerc_mode_t mode,
   input wire logic other_counter_overflow,
   input wire logic repeat_counter_overflow,
   input wire logic err_detect,
   input wire logic err_deferred,
   input wire logic err_uncorrected,
   input wire logic [63:0] wr_data,
   output logic [7:0] wr_check,
   output logic fault_irq,
   output logic recovery_irq,
   output logic error_record_valid,
   output logic error_signal_valid
);
   import cerc_pkg::*;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Only rst_n (cold reset) resets this register; warm reset is not an input, so contents persist.
   logic [63:0] ctrl_reg;
   logic [63:0] ctrl_next;
   logic [63:0] merged;
   logic [63:0] keep_mask;
   wire selected = (record_selector == CERC_RECORD_INDEX);
   wire split_mode = (mode == CERC_MODE_SPLIT);

   always_comb begin
      merged = ctrl_reg;
      case (alias_sel)
         CERC_ALIAS_LOW: merged[31:0] = alias_wdata[31:0];
         CERC_ALIAS_HIGH: merged[63:32] = alias_wdata[31:0];
         CERC_ALIAS_FULL: merged = alias_wdata;
         default: merged = ctrl_reg;
      endcase
   end

   always_comb begin
      keep_mask = CERC_CTRL_MASK;
      if (!HAS_CFI) begin
         keep_mask[CERC_CFI_BIT] = 1'b0;
      end
      if (!split_mode) begin
         keep_mask[CERC_ED_BIT] = 1'b0;
      end
   end

   assign ctrl_next = (alias_wr && selected) ? (merged & keep_mask) : (ctrl_reg & keep_mask);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= CERC_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [63:0] rd_sel;
   always_comb begin
      case (alias_sel)
         CERC_ALIAS_LOW: rd_sel = {32'h00000000, ctrl_reg[31:0]};
         CERC_ALIAS_HIGH: rd_sel = {32'h00000000, ctrl_reg[63:32]};
         CERC_ALIAS_FULL: rd_sel = ctrl_reg;
         default: rd_sel = 64'h0000000000000000;
      endcase
   end
   assign alias_rdata = selected ? rd_sel : 64'h0000000000000000;

   // ----------------------------------------------------------------
   // Reporting and interrupts
   // ----------------------------------------------------------------
   // Non-split modes force reporting on, since bit 0 is held zero there.
   wire report_on = split_mode ? ctrl_reg[CERC_ED_BIT] : 1'b1;

   // ----------------------------------------------------------------
   // Control field decode
   // ----------------------------------------------------------------
   wire cfi_field = ctrl_reg[CERC_CFI_BIT];
   wire fi_field = ctrl_reg[CERC_FI_BIT];
   wire ui_field = ctrl_reg[CERC_UI_BIT];
   wire cfi_on = HAS_CFI && cfi_field;
   wire fi_on = report_on && fi_field;
   wire ui_on = report_on && ui_field;

   // ----------------------------------------------------------------
   // Error classification
   // ----------------------------------------------------------------
   // A deferred error never takes the recovery path, even when it is also flagged uncorrected.
   wire err_deferred_hit = err_detect && err_deferred;
   wire err_uncorr_hit = err_detect && err_uncorrected && !err_deferred;
   wire err_serious = err_deferred_hit || err_uncorr_hit;
   wire any_overflow = other_counter_overflow || repeat_counter_overflow;

   // ----------------------------------------------------------------
   // Interrupts and reporting outputs
   // ----------------------------------------------------------------
   // The overflow bits are sticky in the syndrome record, so this holds the interrupt as a level and
   // does not look at whether the status was kept.
   wire ce_irq = report_on && cfi_on && any_overflow;
   wire due_irq = fi_on && err_serious;
   wire ue_irq = ui_on && err_uncorr_hit;
   assign fault_irq = ce_irq || due_irq;
   assign recovery_irq = ue_irq;
   assign error_record_valid = report_on && err_detect;
   assign error_signal_valid = report_on && err_serious;

   // ----------------------------------------------------------------
   // Check code generation
   // ----------------------------------------------------------------
   // Parity per byte stands in for the RAM code; it never depends on the reporting enable.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_chk
         assign wr_check[gi] = ^wr_data[gi*8 +: 8];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   generate
      if (CERC_REG_WIDTH != 64 || CERC_ALIAS_WIDTH != 32) begin : g_bad_width
         $error("cerc_top supports only a 64-bit record with 32-bit aliases");
      end
   endgenerate
endmodule // cerc_top

// ### sim/cerc_core_model.sv
// Core side model reaching the record through the alias registers.
`timescale 1ns/1ns
module cerc_core_model (
   input wire logic ref_clk,
   output logic [7:0] record_selector = 8'h00,
   output logic alias_wr = 1'b0,
   output cerc_pkg::cerc_alias_t alias_sel = cerc_pkg::CERC_ALIAS_LOW,
   output logic [63:0] alias_wdata = 64'h0
);
   import cerc_pkg::*;
   // A released word is inverted so that a stale value never reads as fresh.
   task automatic put(logic [7:0] s, cerc_alias_t a, logic [63:0] d, logic w);
      record_selector = s;
      alias_sel = a;
      if (w) {alias_wr, alias_wdata} = {1'b1, d};
      @(posedge ref_clk);
      #2 if (w) {alias_wr, alias_wdata} = {1'b0, ~d};
   endtask
endmodule // cerc_core_model

// ### sim/cerc_monitor.sv
// Checker on the error record control ports.
`timescale 1ns/1ns
module cerc_monitor (
   input wire logic ref_clk, rst_n, alias_wr, err_detect, err_deferred, err_uncorrected,
   input wire logic recovery_irq, error_record_valid, error_signal_valid,
   input wire logic [7:0] record_selector, wr_check,
   input wire logic [63:0] alias_wdata, alias_rdata, wr_data,
   input wire cerc_pkg::cerc_alias_t alias_sel,
   input wire cerc_pkg::cerc_mode_t mode
);
   import cerc_pkg::*;
   wire lock = mode != CERC_MODE_SPLIT;
   wire full = record_selector == 8'h01 && alias_sel == CERC_ALIAS_FULL && !lock;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_unsel_zero: assert property (record_selector != 8'h01 |-> alias_rdata == '0) else $error("leak");
   a_full_write: assert property (alias_wr && full ##1 full |-> alias_rdata == ($past(alias_wdata) & CERC_CTRL_MASK))
      else $error("write");
   a_rsvd_zero: assert property ((alias_rdata & ~CERC_CTRL_MASK) == '0) else $error("reserved");
   a_lock_bit0: assert property (lock [*2] |-> !alias_rdata[0]) else $error("bit0");
   a_check_code: assert property (wr_check[7] == ^wr_data[63:56]) else $error("code");
   a_rec_cause: assert property (recovery_irq |-> err_uncorrected && !err_deferred) else $error("recovery");
   a_sig_valid: assert property (error_signal_valid |-> error_record_valid) else $error("signal");
   a_lock_report: assert property (lock |-> error_record_valid == err_detect) else $error("report");
endmodule // cerc_monitor

// ### sim/testbench.sv
// Self-checking bench of the error record control block.
`timescale 1ns/1ns
`define CMP(n, e, s) begin checks_done++; if ((e) !== (s)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
   import cerc_pkg::*;
   logic ref_clk = 0, rst_n = 0, alias_wr, fault_irq, recovery_irq, error_record_valid, error_signal_valid, look = 0, on;
   logic other_counter_overflow = 0, repeat_counter_overflow = 0, err_detect = 0, err_deferred = 0, err_uncorrected = 0;
   logic [7:0] record_selector, wr_check, s, par;
   logic [63:0] alias_wdata, alias_rdata, wr_data = 0, ctl = 0, x, d;
   logic [43:0] e, q[$];
   cerc_alias_t alias_sel, a;
   cerc_mode_t mode = CERC_MODE_SPLIT;
   integer miscompares = 0, checks_done = 0, cycles = 0, seed = 32'ha2f0b4fc;
   always #25 ref_clk = ~ref_clk;
   cerc_top cerc_top_inst (.*);
   cerc_core_model cerc_core_model_inst (.*);
   always @(negedge ref_clk) if (look) begin
      e = q.pop_front();
      `CMP("outputs", e, {alias_rdata[31:0], fault_irq, recovery_irq, error_record_valid, error_signal_valid, wr_check})
   end
   always @(posedge ref_clk) if (++cycles == 2000) begin
      miscompares++;
      conclude();
   end
   task automatic conclude();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      #2 rst_n = 1;
      for (int i = 0; i < 300; i++) begin
         x = {$random(seed), $random(seed)};
         d = {$random(seed), $random(seed)};
         wr_data = x ^ d;
         mode = cerc_mode_t'(x[1:0] % 3);
         {other_counter_overflow, repeat_counter_overflow, err_detect, err_deferred, err_uncorrected} = x[6:2];
         s = x[7] ? x[15:8] : 8'h01;
         a = cerc_alias_t'(x[17:16] % 3);
         if (s == 8'h01 && a != CERC_ALIAS_HIGH) ctl = {32'h0, d[31:0]} & CERC_CTRL_MASK;
         if (mode != CERC_MODE_SPLIT) ctl[0] = 1'b0;
         cerc_core_model_inst.put(s, a, d, 1'b1);
         if (i == 299) begin
            {rst_n, ctl} = 65'h0;
            @(posedge ref_clk);
            #2 rst_n = 1;
         end
         s = x[18] ? x[26:19] : 8'h01;
         a = cerc_alias_t'(x[28:27] % 3);
         on = ctl[0] || mode != CERC_MODE_SPLIT;
         for (int k = 0; k < 8; k++) par[k] = ^wr_data[k*8 +: 8];
         q.push_back({(s == 8'h01 && a != CERC_ALIAS_HIGH) ? ctl[31:0] : 32'h0, on && (ctl[8] &&
            (other_counter_overflow || repeat_counter_overflow) || err_detect && ctl[3] && (err_deferred || err_uncorrected)),
            on && err_detect && ctl[2] && err_uncorrected && !err_deferred, on && err_detect,
            on && err_detect && (err_deferred || err_uncorrected), par});
         look = 1;
         cerc_core_model_inst.put(s, a, d, 1'b0);
         look = 0;
      end
      $display("random access and cold reset test done");
      conclude();
   end
endmodule // testbench
bind cerc_top cerc_monitor cerc_monitor_inst (.*);
